//--- rtl/decoder_regs.svh
/*
  Register offsets, target width, reset values, cycle and word counts of the instruction decoder.
  Assumes a 32-bit APB slave with byte addresses, one aligned word per register.
*/
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH
`define OFS_INSTR 8'h00
`define OFS_DECODE 8'h04
`define OFS_FIELD 8'h08
`define OFS_IMM 8'h0C
`define OFS_TARGET 8'h10
`define OFS_CTRL 8'h14
`define OFS_STATE 8'h18
`define CTRL_RESET 1'b1
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
`define WORDS_ONE 2'h1
`define WORDS_TWO 2'h2
`define TARGET_BITS 12
`endif

//--- rtl/decoder_pkg.sv
/*
  Operation enumeration of the instruction decoder.
  Assumes the decoder module imports this package whole.
*/
package decoder_pkg;
  typedef enum logic [5:0] {
    no_operation = 6'b000000,
    accumulator_magnitude = 6'b000001,
    add_shifted = 6'b000010,
    plus_upper_half = 6'b000011,
    plus_unsigned_operand = 6'b000100,
    and_acc = 6'b000101,
    acc_load_shifted = 6'b000110,
    acc_load_immediate = 6'b000111,
    or_acc = 6'b001000,
    acc_upper_store = 6'b001001,
    acc_lower_store = 6'b001010,
    sub_shifted = 6'b001011,
    conditional_minus_for_division = 6'b001100,
    minus_from_upper_half = 6'b001101,
    minus_unsigned_operand = 6'b001110,
    xor_acc = 6'b001111,
    clear_acc = 6'b010000,
    clear_then_load_upper = 6'b010001,
    clear_then_load_lower = 6'b010010,
    index_reg_load = 6'b010011,
    index_reg_load_immediate = 6'b010100,
    index_pointer_load_immediate = 6'b010101,
    page_pointer_load = 6'b010110,
    page_pointer_load_immediate = 6'b010111,
    index_modify = 6'b011000,
    index_reg_store = 6'b011001,
    jump_always = 6'b011010,
    jump_on_index_nonzero = 6'b011011,
    jump_if_ge_zero = 6'b011100,
    jump_if_gt_zero = 6'b011101,
    jump_on_test_pin_low = 6'b011110,
    jump_if_le_zero = 6'b011111,
    jump_if_below_zero = 6'b100000,
    jump_if_nonzero = 6'b100001,
    jump_on_overflow = 6'b100010,
    jump_if_zero = 6'b100011,
    call_via_acc = 6'b100100,
    call_direct = 6'b100101,
    return_op = 6'b100110,
    product_plus_to_acc = 6'b100111,
    t_register_load = 6'b101000,
    t_load_and_accumulate = 6'b101001,
    t_load_accumulate_copy = 6'b101010,
    multiply_memory = 6'b101011,
    multiply_immediate = 6'b101100,
    product_to_acc = 6'b101101,
    product_minus_from_acc = 6'b101110,
    interrupt_mask_on = 6'b101111,
    interrupt_unmask = 6'b110000,
    flags_restore = 6'b110001,
    stack_pop = 6'b110010,
    stack_push = 6'b110011,
    saturation_off = 6'b110100,
    saturation_on = 6'b110101,
    flags_save = 6'b110110,
    data_copy_forward = 6'b110111,
    port_read = 6'b111000,
    port_write = 6'b111001,
    program_table_read = 6'b111010,
    illegal_word = 6'b111011
  } op_t;
endpackage

//--- rtl/instr_decoder.sv
/*
  APB-attached decoder for 16-bit signal processor instruction words.
  Software writes a word, reads back the operation, fields, cycle and word counts.
  Assumes a single pclk domain and an APB master on the same clock.
*/
// Function
// - Accumulator magnitude is one fixed word, one cycle.
// - Top nibble zero: shifted add with shift, mode bit, seven-bit address.
// - Top nibble 0010: shifted accumulator load, one cycle, one word.
// - Top nibble 0001: shifted subtract, one cycle.
// - Upper store carries three-bit shift; lower store has fixed upper byte.
// - Upper-half add/subtract and unsigned-operand variants, one cycle each.
// - Division step subtract has its own upper byte, mode bit and address.
// - Clear-then-load upper or lower half, one cycle each.
// - Immediate index load: register select bit 8, constant in low byte.
// - Index and page pointer immediates take constant from bit 0.
// - Index modify only updates index registers and pointer, one cycle.
// - Absolute branches take two words, two cycles, target in second word.
// - Conditional branches on accumulator sign, overflow and test input low.
// - Call via accumulator one word two cycles; direct call two words.
// - Return serves subroutines and interrupts, one word, two cycles.
// - Combined op loads multiplicand, accumulates product, copies operand forward.
// - Variant loads multiplicand and accumulates product without the copy.
// - Top bits 100: multiply by 13-bit constant, one cycle.
// - Product to accumulator by load, add or subtract, fixed words.
// - Port read and write: two cycles, port select bits 10..8.
// - Table read copies program word to data memory, three cycles.
// - Stack pop and push each take two cycles, one word.
// - Data copy moves addressed word to the next location, one cycle.
// - Bit 7 clear: direct address with page pointer; set: indirect.
// - Indirect: bit 3 clear loads pointer; bits 5/4 increment/decrement.
`timescale 1ns/1ps
`include "decoder_regs.svh"

module instr_decoder
  import decoder_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output op_t op_out,
  output logic [1:0] cycles_out,
  output logic [1:0] words_out,
  output logic op_strobe
);

  // Word pattern to operation
  function automatic op_t decode_word(input logic [15:0] w);
    op_t r;
    r = illegal_word;
    casez (w)
      16'h7F88: r = accumulator_magnitude;
      16'b0000_????_????_????: r = add_shifted;
      16'b0110_0000_????_????: r = plus_upper_half;
      16'b0110_0001_????_????: r = plus_unsigned_operand;
      16'b0111_1001_????_????: r = and_acc;
      16'b0010_????_????_????: r = acc_load_shifted;
      16'b0111_1110_????_????: r = acc_load_immediate;
      16'b0111_1010_????_????: r = or_acc;
      16'b0101_1???_????_????: r = acc_upper_store;
      16'b0101_0000_????_????: r = acc_lower_store;
      16'b0001_????_????_????: r = sub_shifted;
      16'b0110_0100_????_????: r = conditional_minus_for_division;
      16'b0110_0010_????_????: r = minus_from_upper_half;
      16'b0110_0011_????_????: r = minus_unsigned_operand;
      16'b0111_1000_????_????: r = xor_acc;
      16'h7F89: r = clear_acc;
      16'b0110_0101_????_????: r = clear_then_load_upper;
      16'b0110_0110_????_????: r = clear_then_load_lower;
      16'b0011_100?_????_????: r = index_reg_load;
      16'b0111_000?_????_????: r = index_reg_load_immediate;
      16'b0110_1000_1000_000?: r = index_pointer_load_immediate;
      16'b0110_1111_????_????: r = page_pointer_load;
      16'b0110_1110_0000_000?: r = page_pointer_load_immediate;
      16'b0110_1000_????_????: r = index_modify;
      16'b0011_000?_????_????: r = index_reg_store;
      16'hF900: r = jump_always;
      16'hF400: r = jump_on_index_nonzero;
      16'hFD00: r = jump_if_ge_zero;
      16'hFC00: r = jump_if_gt_zero;
      16'hF600: r = jump_on_test_pin_low;
      16'hFB00: r = jump_if_le_zero;
      16'hFA00: r = jump_if_below_zero;
      16'hFE00: r = jump_if_nonzero;
      16'hF500: r = jump_on_overflow;
      16'hFF00: r = jump_if_zero;
      16'h7F8C: r = call_via_acc;
      16'hF800: r = call_direct;
      16'h7F8D: r = return_op;
      16'h7F8F: r = product_plus_to_acc;
      16'b0110_1010_????_????: r = t_register_load;
      16'b0110_1100_????_????: r = t_load_and_accumulate;
      16'b0110_1011_????_????: r = t_load_accumulate_copy;
      16'b0110_1101_????_????: r = multiply_memory;
      16'b100?_????_????_????: r = multiply_immediate;
      16'h7F8E: r = product_to_acc;
      16'h7F90: r = product_minus_from_acc;
      16'h7F81: r = interrupt_mask_on;
      16'h7F82: r = interrupt_unmask;
      16'b0111_1011_????_????: r = flags_restore;
      16'h7F80: r = no_operation;
      16'h7F9D: r = stack_pop;
      16'h7F9C: r = stack_push;
      16'h7F8A: r = saturation_off;
      16'h7F8B: r = saturation_on;
      16'b0111_1100_????_????: r = flags_save;
      16'b0110_1001_????_????: r = data_copy_forward;
      16'b0100_0???_????_????: r = port_read;
      16'b0100_1???_????_????: r = port_write;
      16'b0110_0111_????_????: r = program_table_read;
      default: r = illegal_word;
    endcase
    return r;
  endfunction

  // Cycle count per operation
  function automatic logic [1:0] cycles_of(input op_t o);
    logic [1:0] c;
    c = `CYC_ONE;
    case (o)
      jump_always, jump_on_index_nonzero, jump_if_ge_zero, jump_if_gt_zero, jump_on_test_pin_low,
      jump_if_le_zero, jump_if_below_zero, jump_if_nonzero, jump_on_overflow, jump_if_zero,
      call_direct, call_via_acc, return_op, port_read, port_write, stack_pop, stack_push:
        c = `CYC_TWO;
      program_table_read: c = `CYC_THREE;
      default: c = `CYC_ONE;
    endcase
    return c;
  endfunction

  // Word count per operation
  function automatic logic [1:0] words_of(input op_t o);
    logic [1:0] n;
    n = `WORDS_ONE;
    case (o)
      jump_always, jump_on_index_nonzero, jump_if_ge_zero, jump_if_gt_zero, jump_on_test_pin_low,
      jump_if_le_zero, jump_if_below_zero, jump_if_nonzero, jump_on_overflow, jump_if_zero,
      call_direct: n = `WORDS_TWO;
      default: n = `WORDS_ONE;
    endcase
    return n;
  endfunction

  // Operations whose low byte addresses data memory
  function automatic logic uses_memory(input op_t o);
    logic m;
    m = 1'b1;
    case (o)
      accumulator_magnitude, acc_load_immediate, clear_acc, index_reg_load_immediate,
      index_pointer_load_immediate, page_pointer_load_immediate, jump_always, jump_on_index_nonzero,
      jump_if_ge_zero, jump_if_gt_zero, jump_on_test_pin_low, jump_if_le_zero, jump_if_below_zero,
      jump_if_nonzero, jump_on_overflow, jump_if_zero, call_via_acc, call_direct, return_op,
      product_plus_to_acc, multiply_immediate, product_to_acc, product_minus_from_acc,
      interrupt_mask_on, interrupt_unmask, no_operation, stack_pop, stack_push, saturation_off,
      saturation_on, illegal_word: m = 1'b0;
      default: m = 1'b1;
    endcase
    return m;
  endfunction

  // Held state
  logic [15:0] word_reg;
  op_t op_reg;
  logic [1:0] cyc_reg;
  logic [1:0] words_reg;
  logic mem_reg;
  logic illegal_reg;
  logic [31:0] field_reg;
  logic [12:0] imm_reg;
  logic [`TARGET_BITS-1:0] target_reg;
  logic target_wait_reg;
  logic page_reg;
  logic index_ptr_reg;
  logic enable_reg;
  logic strobe_reg;
  logic primed_reg;
  logic [31:0] prdata_reg;
  logic err_reg;

  // Bus decode
  wire logic [7:0] ofs = paddr[7:0];
  wire logic hit_instr = (ofs == `OFS_INSTR);
  wire logic hit_decode = (ofs == `OFS_DECODE);
  wire logic hit_field = (ofs == `OFS_FIELD);
  wire logic hit_imm = (ofs == `OFS_IMM);
  wire logic hit_target = (ofs == `OFS_TARGET);
  wire logic hit_ctrl = (ofs == `OFS_CTRL);
  wire logic hit_state = (ofs == `OFS_STATE);
  wire logic hit_any = hit_instr | hit_decode | hit_field | hit_imm | hit_target | hit_ctrl | hit_state;
  wire logic access_done = ce & psel & penable & primed_reg;
  wire logic wr_done = access_done & pwrite;
  wire logic capture = ce & psel & ~primed_reg;

  // New instruction word and its decode
  wire logic [15:0] w = pwdata[15:0];
  wire op_t dec_op = decode_word(w);
  wire logic dec_mem = uses_memory(dec_op);
  wire logic dec_ind = dec_mem & w[7];
  wire logic [7:0] dec_addr = dec_ind ? 8'h00 : {page_reg, w[6:0]};
  wire logic dec_inc = dec_ind & w[5];
  wire logic dec_dec = dec_ind & w[4];
  wire logic dec_ptr_load = dec_ind & ~w[3];
  wire logic dec_resv_bad = dec_ind & (w[6] | w[2] | w[1]);
  wire logic [3:0] dec_shift = (dec_op == acc_upper_store) ? {1'b0, w[10:8]} : w[11:8];
  wire logic [2:0] dec_port = w[10:8];
  wire logic dec_rsel = w[8];

  // Immediate constant by operation
  wire logic [12:0] dec_imm =
    (dec_op == multiply_immediate) ? w[12:0] :
    ((dec_op == index_pointer_load_immediate) || (dec_op == page_pointer_load_immediate)) ?
      {12'h000, w[0]} :
    ((dec_op == acc_load_immediate) || (dec_op == index_reg_load_immediate)) ?
      {5'h00, w[7:0]} : 13'h0000;

  wire logic [31:0] dec_field = {11'h000, dec_resv_bad, w[0], dec_ptr_load, dec_dec, dec_inc,
    dec_addr, dec_rsel, dec_port, dec_shift};
  wire logic take_word = wr_done & hit_instr & enable_reg;
  wire logic take_target = take_word & target_wait_reg;
  wire logic take_decode = take_word & ~target_wait_reg;

  // Read multiplexer
  wire logic [31:0] rd_mux =
    hit_instr ? {16'h0000, word_reg} :
    hit_decode ? {18'h00000, dec_ind_state(), illegal_reg, mem_reg, target_wait_reg, words_reg, cyc_reg,
      op_reg} :
    hit_field ? field_reg :
    hit_imm ? {19'h00000, imm_reg} :
    hit_target ? {20'h00000, target_reg} :
    hit_ctrl ? {31'h0000_0000, enable_reg} :
    hit_state ? {30'h0000_0000, index_ptr_reg, page_reg} : 32'h0000_0000;

  function automatic logic dec_ind_state();
    return mem_reg & word_reg[7];
  endfunction

  // Bus handshake outputs
  assign pready = penable & ce & primed_reg;
  assign prdata = prdata_reg;
  assign pslverr = err_reg & pready;
  assign op_out = op_reg;
  assign cycles_out = cyc_reg;
  assign words_out = words_reg;
  assign op_strobe = strobe_reg;

  // Access priming and read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primed_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else if (capture) begin
      primed_reg <= 1'b1;
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      err_reg <= ~hit_any;
    end else if (access_done) begin
      primed_reg <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= `CTRL_RESET;
    end else if (wr_done & hit_ctrl) begin
      enable_reg <= pwdata[0];
    end
  end

  // Decode results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_reg <= 16'h0000;
      op_reg <= no_operation;
      cyc_reg <= `CYC_ONE;
      words_reg <= `WORDS_ONE;
      mem_reg <= 1'b0;
      illegal_reg <= 1'b0;
      field_reg <= 32'h0000_0000;
      imm_reg <= 13'h0000;
    end else if (take_decode) begin
      word_reg <= w;
      op_reg <= (dec_op == illegal_word) ? no_operation : dec_op;
      cyc_reg <= cycles_of(dec_op);
      words_reg <= words_of(dec_op);
      mem_reg <= dec_mem;
      illegal_reg <= (dec_op == illegal_word);
      field_reg <= dec_field;
      imm_reg <= dec_imm;
    end
  end

  // Second word of a two-word instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_reg <= 12'h000;
      target_wait_reg <= 1'b0;
    end else if (take_target) begin
      target_reg <= w[`TARGET_BITS-1:0];
      target_wait_reg <= 1'b0;
    end else if (take_decode) begin
      target_wait_reg <= (words_of(dec_op) == `WORDS_TWO);
    end
  end

  // Tracked page and index pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_reg <= 1'b0;
      index_ptr_reg <= 1'b0;
    end else if (take_decode) begin
      if (dec_op == page_pointer_load_immediate) begin
        page_reg <= w[0];
      end
      if (dec_op == index_pointer_load_immediate) begin
        index_ptr_reg <= w[0];
      end else if (dec_ptr_load) begin
        index_ptr_reg <= w[0];
      end
    end
  end

  // Pulse per decoded word, one cycle long while ce stays high; held while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_reg <= 1'b0;
    end else if (ce) begin
      strobe_reg <= take_decode;
    end
  end

endmodule

//--- bench/instr_decoder_chk.sv
/*
  Port checker for the instruction decoder: counts per operation, decode from written word.
  Assumes it is bound into instr_decoder and runs on pclk alone.
*/
`timescale 1ns/1ps
module instr_decoder_chk
  import decoder_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input op_t op_out,
  input wire logic [1:0] cycles_out,
  input wire logic [1:0] words_out,
  input wire logic op_strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Two-word absolute branches and the direct call
  wire logic is_jump = op_out inside {jump_always, jump_on_index_nonzero, jump_if_ge_zero, jump_if_gt_zero,
    jump_on_test_pin_low, jump_if_le_zero, jump_if_below_zero, jump_if_nonzero, jump_on_overflow,
    jump_if_zero, call_direct};
  // Accepted instruction write followed by its decode pulse
  sequence s_instr_wr;
    psel && penable && pready && pwrite && paddr == '0;
  endsequence
  property p_counts(c, logic [1:0] cy, logic [1:0] wd);
    c |-> cycles_out == cy && words_out == wd;
  endproperty
  // Cycle and word counts tied to the decoded operation
  a_magnitude_counts: assert property (p_counts(op_out == accumulator_magnitude, 2'h1, 2'h1))
    else $error("magnitude counts wrong");
  a_branch_counts: assert property (p_counts(is_jump, 2'h2, 2'h2))
    else $error("branch counts wrong");
  a_call_acc_counts: assert property (p_counts(op_out == call_via_acc, 2'h2, 2'h1))
    else $error("call via acc counts wrong");
  a_return_counts: assert property (p_counts(op_out == return_op, 2'h2, 2'h1))
    else $error("return counts wrong");
  a_port_counts: assert property (p_counts(op_out inside {port_read, port_write}, 2'h2, 2'h1))
    else $error("port counts wrong");
  a_table_counts: assert property (p_counts(op_out == program_table_read, 2'h3, 2'h1))
    else $error("table read counts wrong");
  a_stack_counts: assert property (p_counts(op_out inside {stack_pop, stack_push}, 2'h2, 2'h1))
    else $error("stack counts wrong");
  a_nop_counts: assert property (p_counts(op_out == no_operation, 2'h1, 2'h1))
    else $error("no-operation counts wrong");
  // Operation follows the top bits of the word written one edge earlier
  a_add_from_word: assert property (op_strobe && $past(pwdata[15:12]) == 4'h0 |-> op_out == add_shifted)
    else $error("shifted add not decoded");
  a_load_from_word: assert property (op_strobe && $past(pwdata[15:12]) == 4'h2 |-> op_out == acc_load_shifted)
    else $error("shifted load not decoded");
  a_sub_from_word: assert property (op_strobe && $past(pwdata[15:12]) == 4'h1 |-> op_out == sub_shifted)
    else $error("shifted subtract not decoded");
  a_mult_from_word: assert property (op_strobe && $past(pwdata[15:13]) == 3'h4 |-> op_out == multiply_immediate)
    else $error("immediate multiply not decoded");
  c_decode: cover property (s_instr_wr ##1 op_strobe);
endmodule

bind instr_decoder instr_decoder_chk #(.ADDR_W(ADDR_W)) u_instr_decoder_chk (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .op_out(op_out), .cycles_out(cycles_out), .words_out(words_out), .op_strobe(op_strobe));

//--- bench/prog_mem.sv
/*
  Program memory model holding the instruction words fetched in turn by the bench.
  Assumes a combinational read; beyond the table it returns the illegal word 16'ha000.
*/
`timescale 1ns/1ps
module prog_mem (
  input wire logic [5:0] addr,
  output logic [15:0] word
);
  logic [15:0] rom [0:42];
  // Words in fetch order
  initial begin
    rom = '{16'h7f88, 16'h0a35, 16'h23a1, 16'h1f7f, 16'h5d12, 16'h5012, 16'h6012, 16'h6112, 16'h6212,
      16'h6312, 16'h6412, 16'h6512, 16'h6612, 16'h71c3, 16'h6881, 16'h6e01, 16'h6890, 16'hf900,
      16'hf400, 16'hfd00, 16'hfc00, 16'hf600, 16'hfb00, 16'hfa00, 16'hfe00, 16'hf500, 16'hff00,
      16'h7f8c, 16'hf800, 16'h7f8d, 16'h6b12, 16'h6c12, 16'h9abc, 16'h7f8e, 16'h7f8f, 16'h7f90,
      16'h4512, 16'h4d12, 16'h6712, 16'h7f9d, 16'h7f9c, 16'h6912, 16'ha000};
  end
  // Read port
  assign word = (addr <= 6'h2a) ? rom[addr] : 16'ha000;
endmodule

//--- bench/tb_dsp_instruction_decoder.sv
/*
  Testbench for the instruction decoder: APB writes of words, reads of decode results.
  Assumes the decoder, its package and register header, the checker and prog_mem.
*/
`timescale 1ns/1ps
`include "decoder_regs.svh"
module tb_dsp_instruction_decoder import decoder_pkg::*;;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, op_strobe, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] cycles_out, words_out;
  logic [5:0] pm_addr;
  logic [15:0] pm_word;
  logic [3:0] cw;
  op_t op_out;
  int failures, n_compared;
  // Program words whose low byte is a data memory operand
  logic [42:0] mem_ops = 43'h270_c001_1ffe;
  // Expected operation per program word
  op_t exp_op [0:42] = '{accumulator_magnitude, add_shifted, acc_load_shifted, sub_shifted,
    acc_upper_store, acc_lower_store, plus_upper_half, plus_unsigned_operand, minus_from_upper_half,
    minus_unsigned_operand, conditional_minus_for_division, clear_then_load_upper, clear_then_load_lower,
    index_reg_load_immediate, index_pointer_load_immediate, page_pointer_load_immediate, index_modify,
    jump_always, jump_on_index_nonzero, jump_if_ge_zero, jump_if_gt_zero, jump_on_test_pin_low,
    jump_if_le_zero, jump_if_below_zero, jump_if_nonzero, jump_on_overflow, jump_if_zero, call_via_acc,
    call_direct, return_op, t_load_accumulate_copy, t_load_and_accumulate, multiply_immediate,
    product_to_acc, product_plus_to_acc, product_minus_from_acc, port_read, port_write,
    program_table_read, stack_pop, stack_push, data_copy_forward, no_operation};

  instr_decoder u_instr_decoder (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_out(op_out), .cycles_out(cycles_out), .words_out(words_out), .op_strobe(op_strobe));
  prog_mem u_prog_mem (.addr(pm_addr), .word(pm_word));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Words and cycles taken by each operation, as {words, cycles}
  function automatic logic [3:0] counts(input op_t o);
    case (o)
      jump_always, jump_on_index_nonzero, jump_if_ge_zero, jump_if_gt_zero, jump_on_test_pin_low, jump_if_le_zero,
        jump_if_below_zero, jump_if_nonzero, jump_on_overflow, jump_if_zero, call_direct: counts = 4'ha;
      call_via_acc, return_op, port_read, port_write, stack_pop, stack_push: counts = 4'h6;
      program_table_read: counts = 4'h7;
      default: counts = 4'h5;
    endcase
  endfunction

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high at a rising edge, for at most 20 edges
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t no ready", $time);
      print_verdict();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    cmp(r, x, what);
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pm_addr = 6'h00;
    failures = 0;
    n_compared = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`OFS_CTRL, 32'h0000_0001, "ctrl reset");
    rd_chk(`OFS_DECODE, 32'h0000_0140, "decode reset");
    rd_chk(`OFS_STATE, 32'h0000_0000, "state reset");
    $display("test reset done");
    for (int i = 0; i <= 42; i++) begin
      pm_addr = 6'(i);
      @(negedge pclk);
      @(posedge pclk);
      wr(`OFS_INSTR, {16'h0000, pm_word});
      cw = counts(exp_op[i]);
      rd_chk(`OFS_DECODE, {18'h0_0000, mem_ops[i] & pm_word[7], i == 42, mem_ops[i], cw[3:2] == 2'h2, cw,
        exp_op[i]}, "decode");
      cmp({22'h00_0000, words_out, cycles_out, op_out}, {22'h00_0000, cw, exp_op[i]}, "ports");
      if (cw[3:2] == 2'h2) begin
        wr(`OFS_INSTR, 32'h0000_f5a0 + i);
        rd_chk(`OFS_TARGET, 32'h0000_05a0 + i, "target word");
        rd_chk(`OFS_DECODE, {22'h00_0000, cw, exp_op[i]}, "target taken");
      end
    end
    $display("test decode table done");
    wr(`OFS_INSTR, 32'h0000_6e01);
    rd_chk(`OFS_IMM, 32'h0000_0001, "page immediate");
    wr(`OFS_INSTR, 32'h0000_0a35);
    rd_chk(`OFS_FIELD, 32'h0008_b52a, "direct fields");
    wr(`OFS_INSTR, 32'h0000_23a1);
    rd_chk(`OFS_FIELD, 32'h000d_00b3, "indirect fields");
    rd_chk(`OFS_STATE, 32'h0000_0003, "pointers");
    wr(`OFS_INSTR, 32'h0000_23c8);
    rd_chk(`OFS_FIELD, 32'h0010_00b3, "reserved bits");
    rd_chk(`OFS_STATE, 32'h0000_0003, "pointer kept");
    wr(`OFS_INSTR, 32'h0000_5d12);
    rd_chk(`OFS_FIELD, 32'h0000_92d5, "store shift");
    wr(`OFS_INSTR, 32'h0000_9abc);
    rd_chk(`OFS_IMM, 32'h0000_1abc, "multiply constant");
    wr(`OFS_INSTR, 32'h0000_71c3);
    rd_chk(`OFS_IMM, 32'h0000_00c3, "index constant");
    $display("test fields done");
    apb(1'b0, 8'h1c, 32'h0000_0000, rd, err);
    cmp({31'h0000_0000, err}, 32'h0000_0001, "unmapped error");
    cmp(rd, 32'h0000_0000, "unmapped data");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`OFS_DECODE, 32'h0000_0140, "decode after reset");
    $display("test errors and reset done");
    print_verdict();
  end
endmodule
